// [common/msmd_defs.svh]
// Purpose: constants for the mode select and map decode block
// Assumes: 16-bit cpu address space, 8-bit registers on a 32-bit bus
// Notes: offsets are byte addresses on the register bus
// How it works
// - decode order is registers first, then RAM, boot ROM, EEPROM, then ROM.
// - an overlapped address reaches only the winning resource, nothing below it.
// - bootstrap ROM appears internally at $BE00-$BFFF, enabled from reset only in bootstrap mode.
// - expanded modes map ROM only with rom_enable_config; other modes always map it.
// - small EEPROM decodes fixed at $B600-$B7FF, timed like internal ROM.
// - large EEPROM defaults to $F800-$FFFF, eeprom_page_select moves it per 4K.
// - strap pins b,a select: 10 single-chip, 11 expanded, 00 bootstrap, 01 test.
// - straps must be valid in reset; ignored once reset is released.
// - outside reset mode_pin_a is an open-drain low fetch marker each instruction.
// - normal modes fetch reset vector at $FFFA, special modes at $BFFA.
// - at reset release special flag takes inverse of pin b, mode_a latch pin a.
// - mode flags always readable, free writes in special modes, mode_a once otherwise.
// - once special_mode_flag clears it cannot be set again until reset.
// - boot_rom_enable writable only in special modes, maps $BE00-$BFFF while special.
// - visibility/eclock-off bit writes once; resets 1 in test mode, else 0.
// - expanded and test modes: bit set drives internal read data externally.
// - single-chip and bootstrap: bit 0 outputs E clock, bit 1 drives E low.
// - misc register reset values follow the strap mode; boot enable only in bootstrap.
// - RAM resets to $0000, 64-byte registers to $1000, each movable per 4K.
// - in expanded modes rom_enable_config 0 removes ROM from decode and passes it external.
`ifndef MSMD_DEFS_SVH
`define MSMD_DEFS_SVH
`define MSMD_OFF_MISC 16'h103C
`define MSMD_OFF_MAP 16'h1000
`define MSMD_OFF_CFG 16'h1004
`define MSMD_OFF_STAT 16'h1008
`define MSMD_B_BOOT 7
`define MSMD_B_SPEC 6
`define MSMD_B_MODEA 5
`define MSMD_B_VIS 4
`define MSMD_F_PSEL 3:0
`define MSMD_PSEL_RST 4'h6
`define MSMD_MAP_RST 8'h01
`define MSMD_B_ROM_EN 1
`define MSMD_B_EEON 0
`define MSMD_F_EEPG 7:4
`define MSMD_CFG_RST 8'hF3
`define MSMD_PAGE_MASK 16'hF000
`define MSMD_REG_MASK 16'hFFC0
`define MSMD_BOOT_LO 16'hBE00
`define MSMD_BOOT_HI 16'hBFFF
`define MSMD_EES_LO 16'hB600
`define MSMD_EES_HI 16'hB7FF
`define MSMD_EEL_OFF 16'h0800
`define MSMD_EEL_MASK 16'hF800
`define MSMD_VEC_NORM 16'hFFFA
`define MSMD_VEC_SPEC 16'hBFFA
`define MSMD_TOP 16'hFFFF
`define MSMD_RESP_OK 2'h0
`define MSMD_RESP_DEC 2'h3
`endif

// [common/msmd_pkg.sv]
// Purpose: types for the mode select and map decode block
// Assumes: used with msmd_defs.svh
// Notes: mode codes are the strap levels {b,a}
package msmd_pkg;
  typedef enum logic [1:0] {
    MSMD_BOOTSTRAP = 2'b00,
    MSMD_TEST = 2'b01,
    MSMD_SINGLE = 2'b10,
    MSMD_EXPANDED = 2'b11
  } msmd_mode_t;
  typedef enum logic [2:0] {
    MSMD_SEL_NONE = 3'b000,
    MSMD_SEL_REGS = 3'b001,
    MSMD_SEL_RAM = 3'b010,
    MSMD_SEL_BOOT = 3'b011,
    MSMD_SEL_EEPROM = 3'b100,
    MSMD_SEL_ROM = 3'b101,
    MSMD_SEL_EXT = 3'b110
  } msmd_sel_t;
endpackage

// [testbench/msmd_board.sv]
// Purpose: board strap network for msmd_top
// Assumes: strap levels come from the bench
// Notes: external bus devices are not modelled
`timescale 1ns/1ns
`default_nettype none
module msmd_board (
  input wire logic strap_a,
  input wire logic strap_b,
  input wire logic pin_a_oe,
  input wire logic pin_a_out,
  output logic pin_a,
  output logic pin_b
);
  // ==========
  // straps
  // strap resistors hold levels through reset
  // open drain: the strap wins unless the device pulls low
  assign pin_a = pin_a_oe ? pin_a_out : strap_a;
  assign pin_b = strap_b;
endmodule
`default_nettype wire

// [testbench/msmd_chk_sva.sv]
// Purpose: port checks for msmd_top
// Assumes: one clock aclk, synchronous aresetn
// Notes: bound to every msmd_top
`timescale 1ns/1ns
`default_nettype none
module msmd_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic mode_pin_a_out,
  input wire logic mode_pin_a_oe,
  input wire logic cpu_valid,
  input wire logic cpu_fetch_first,
  input wire msmd_pkg::msmd_sel_t cpu_sel,
  input wire logic ext_cycle,
  input wire logic ext_data_drive,
  input wire logic [15:0] reset_vector
);
  import msmd_pkg::*;
  // ==========
  // assertions
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fetch_marker: assert property ($past(aresetn) |-> mode_pin_a_oe == $past(cpu_fetch_first))
    else $error("fetch marker not one cycle after fetch");
  a_marker_low: assert property (mode_pin_a_oe |-> !mode_pin_a_out)
    else $error("marker pin driven high");
  a_vector_legal: assert property (reset_vector inside {16'hFFFA, 16'hBFFA})
    else $error("reset vector illegal");
  // once normal, the vector may never go back to the special one
  // the step from the reset value to the mode's vector on the first edge after release is allowed
  a_vector_once: assert property ($past(aresetn) && $past(aresetn, 2) && !$stable(reset_vector)
    |-> reset_vector == 16'hFFFA)
    else $error("reset vector returned to special");
  a_sel_idle: assert property (!cpu_valid |=> cpu_sel == MSMD_SEL_NONE)
    else $error("select without access");
  a_ext_pulse: assert property ($past(aresetn) |-> ext_cycle == (cpu_sel == MSMD_SEL_EXT))
    else $error("external cycle disagrees with select");
  a_drive_internal: assert property (ext_data_drive |-> !(cpu_sel inside {MSMD_SEL_NONE, MSMD_SEL_EXT}))
    else $error("visibility on non internal access");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read answer late or wide");
  c_ext: cover property (ext_cycle);
  c_drive: cover property (ext_data_drive);
  c_boot: cover property (cpu_sel == MSMD_SEL_BOOT);
endmodule
bind msmd_top msmd_chk u_msmd_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .mode_pin_a_out, .mode_pin_a_oe, .cpu_valid,
  .cpu_fetch_first, .cpu_sel, .ext_cycle, .ext_data_drive, .reset_vector);
`default_nettype wire

// [testbench/test_mode_select_and_map_decode.sv]
// Purpose: self-checking bench for msmd_top
// Assumes: default parameters, small eeprom, rom at D000
// Notes: straps flip after each release to prove they are ignored
`timescale 1ns/1ns
`default_nettype none
`include "msmd_defs.svh"
module test_mode_select_and_map_decode;
  import msmd_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, strap_a = 1'b0, strap_b = 1'b1;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0, cpu_addr = '0, reset_vector;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic cpu_valid = 1'b0, cpu_write = 1'b0, cpu_fetch_first = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_cycle, ext_data_drive, eclk_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic mode_pin_a_in, mode_pin_a_out, mode_pin_a_oe, mode_pin_b_in;
  msmd_sel_t cpu_sel;
  int err_count = 0, checks = 0;
  msmd_board u_msmd_board (.strap_a, .strap_b, .pin_a_oe(mode_pin_a_oe), .pin_a_out(mode_pin_a_out),
    .pin_a(mode_pin_a_in), .pin_b(mode_pin_b_in));
  msmd_top u_msmd_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_pin_a_in, .mode_pin_a_out,
    .mode_pin_a_oe, .mode_pin_b_in, .cpu_addr, .cpu_valid, .cpu_write, .cpu_fetch_first, .cpu_sel, .ext_cycle,
    .ext_data_drive, .reset_vector, .eclk_pin);
  initial forever #2 aclk = ~aclk;
  // ==========
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, (a == `MSMD_OFF_STAT) ? `MSMD_RESP_DEC : `MSMD_RESP_OK);
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
    // unmapped data is left open, only the response counts there
    if (er == `MSMD_RESP_OK) chk("rdata", s_axi_rdata, {24'h00_0000, e});
  endtask
  task automatic dec(input logic [15:0] a, input msmd_sel_t s);
    @(posedge aclk);
    cpu_addr <= a;
    cpu_valid <= 1'b1;
    @(posedge aclk);
    cpu_valid <= 1'b0;
    #1;
    chk("sel", cpu_sel, s);
    chk("ext", ext_cycle, s == MSMD_SEL_EXT);
  endtask
  task automatic eck(input logic run);
    int hi = 0;
    repeat (8) begin
      @(posedge aclk);
      #1;
      hi += eclk_pin;
    end
    chk("eclk", hi != 0, run);
  endtask
  task automatic start(input logic b, input logic a, input logic [7:0] misc, input logic [15:0] vec);
    @(posedge aclk);
    aresetn <= 1'b0;
    strap_b <= b;
    strap_a <= a;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    strap_b <= ~b;
    strap_a <= ~a;
    #1;
    chk("vector", reset_vector, vec);
    rdchk(`MSMD_OFF_MISC, misc, `MSMD_RESP_OK);
  endtask
  // ==========
  // scenarios
  task automatic t_single();
    start(1'b1, 1'b0, 8'h06, `MSMD_VEC_NORM);
    dec(16'h1000, MSMD_SEL_REGS);
    dec(16'h0000, MSMD_SEL_RAM);
    dec(`MSMD_EES_LO, MSMD_SEL_EEPROM);
    dec(`MSMD_EES_HI, MSMD_SEL_EEPROM);
    dec(16'h8000, MSMD_SEL_NONE);
    dec(16'hBF00, MSMD_SEL_NONE);
    wr(`MSMD_OFF_CFG, 8'hF1);
    dec(16'hFFF0, MSMD_SEL_ROM);
    rdchk(16'h1100, 8'h00, `MSMD_RESP_DEC);
    @(posedge aclk);
    cpu_fetch_first <= 1'b1;
    @(posedge aclk);
    cpu_fetch_first <= 1'b0;
    #1;
    chk("marker", mode_pin_a_in, 1'b0);
    @(posedge aclk);
    #1;
    chk("release", mode_pin_a_in, 1'b1);
    eck(1'b1);
    wr(`MSMD_OFF_MISC, 8'h16);
    rdchk(`MSMD_OFF_MISC, 8'h16, `MSMD_RESP_OK);
    eck(1'b0);
    wr(`MSMD_OFF_MISC, 8'hE6);
    rdchk(`MSMD_OFF_MISC, 8'h16, `MSMD_RESP_OK);
    $display("single chip done");
  endtask
  task automatic t_expanded();
    start(1'b1, 1'b1, 8'h26, `MSMD_VEC_NORM);
    dec(16'h8000, MSMD_SEL_EXT);
    dec(16'hFFF0, MSMD_SEL_ROM);
    wr(`MSMD_OFF_CFG, 8'hF1);
    dec(16'hFFF0, MSMD_SEL_EXT);
    dec(16'h1000, MSMD_SEL_REGS);
    chk("drive", ext_data_drive, 1'b0);
    wr(`MSMD_OFF_MISC, 8'h36);
    rdchk(`MSMD_OFF_MISC, 8'h36, `MSMD_RESP_OK);
    dec(16'h1000, MSMD_SEL_REGS);
    chk("drive", ext_data_drive, 1'b1);
    @(posedge aclk);
    cpu_write <= 1'b1;
    dec(16'h1000, MSMD_SEL_REGS);
    chk("drive", ext_data_drive, 1'b0);
    @(posedge aclk);
    cpu_write <= 1'b0;
    $display("expanded done");
  endtask
  task automatic t_boot();
    start(1'b0, 1'b0, 8'hC6, `MSMD_VEC_SPEC);
    dec(`MSMD_BOOT_LO, MSMD_SEL_BOOT);
    dec(16'hBF00, MSMD_SEL_BOOT);
    rdchk(`MSMD_OFF_STAT, 8'h1C, `MSMD_RESP_OK);
    wr(`MSMD_OFF_STAT, 8'h00);
    wr(`MSMD_OFF_MAP, 8'h11);
    dec(16'h1000, MSMD_SEL_REGS);
    dec(16'h1040, MSMD_SEL_RAM);
    wr(`MSMD_OFF_MAP, 8'hD1);
    dec(16'hD000, MSMD_SEL_RAM);
    dec(16'hD200, MSMD_SEL_ROM);
    wr(`MSMD_OFF_MISC, 8'h46);
    dec(16'hBF00, MSMD_SEL_NONE);
    wr(`MSMD_OFF_MISC, 8'hC6);
    rdchk(`MSMD_OFF_MISC, 8'hC6, `MSMD_RESP_OK);
    $display("bootstrap done");
  endtask
  task automatic t_test();
    start(1'b0, 1'b1, 8'h76, `MSMD_VEC_SPEC);
    wr(`MSMD_OFF_MISC, 8'h16);
    #1;
    chk("vector", reset_vector, `MSMD_VEC_NORM);
    wr(`MSMD_OFF_MISC, 8'h76);
    rdchk(`MSMD_OFF_MISC, 8'h16, `MSMD_RESP_OK);
    $display("special test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    t_single();
    t_expanded();
    t_boot();
    t_test();
    print_verdict();
  end
  // the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire

// [verilog/msmd_top.sv]
// Purpose: strap mode latch, misc control register and on-chip map decode
// Assumes: one clock aclk, synchronous active-low aresetn, AXI4-Lite registers
// Notes: decode answer is registered one cycle after cpu_valid
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "msmd_defs.svh"
module msmd_top #(
  parameter int RAM_BYTES = 512,
  parameter logic [15:0] ROM_BASE = 16'hD000,
  parameter bit EE_LARGE = 1'b0,
  parameter int E_DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_pin_a_in,
  output logic mode_pin_a_out,
  output logic mode_pin_a_oe,
  input wire logic mode_pin_b_in,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_valid,
  input wire logic cpu_write,
  input wire logic cpu_fetch_first,
  output msmd_pkg::msmd_sel_t cpu_sel,
  output logic ext_cycle,
  output logic ext_data_drive,
  output logic [15:0] reset_vector,
  output logic eclk_pin
);
  import msmd_pkg::*;

  // ==========================================================
  // parameter checks
  if (RAM_BYTES < 64 || RAM_BYTES > 4096) begin : g_bad_ram
    $error("RAM_BYTES must lie in 64..4096");
  end
  if (E_DIV < 2 || E_DIV > 255) begin : g_bad_div
    $error("E_DIV must lie in 2..255");
  end
  if (ROM_BASE[11:0] != 12'h000) begin : g_bad_rom
    $error("ROM_BASE must sit on a 4K boundary");
  end

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] reg_pick(input logic [15:0] a);
    reg_pick = (a == `MSMD_OFF_MISC) ? 8'h01 :
               (a == `MSMD_OFF_MAP) ? 8'h02 :
               (a == `MSMD_OFF_CFG) ? 8'h04 :
               (a == `MSMD_OFF_STAT) ? 8'h08 : 8'h00;
  endfunction

  // ==========================================================
  // strap pin synchronisers and reset capture
  logic [1:0] pin_a_sync_r;
  logic [1:0] pin_b_sync_r;
  msmd_mode_t mode_r;

  always_ff @(posedge aclk) begin
    pin_a_sync_r <= {pin_a_sync_r[0], mode_pin_a_in};
    pin_b_sync_r <= {pin_b_sync_r[0], mode_pin_b_in};
  end

  // mode follows the pins only while reset is held, so the last level before
  // release is the one kept; afterwards the pins carry other functions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= msmd_mode_t'({pin_b_sync_r[1], pin_a_sync_r[1]});
    end
  end

  // ==========================================================
  // register storage
  logic boot_r;
  logic spec_flag_r;
  logic mode_a_r;
  logic vis_eoff_r;
  logic [3:0] psel_r;
  logic mode_a_written_r;
  logic vis_written_r;
  logic [7:0] map_r;
  logic [7:0] cfg_r;
  logic wr_fire;
  logic [15:0] wr_addr_r;
  logic [7:0] wr_byte_r;
  logic wr_lane_r;
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] wr_pick;
  logic [7:0] misc_rd;
  logic [7:0] stat_rd;
  logic misc_wr;

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_pick = reg_pick(wr_addr_r);
  // any lane-0 misc write uses up the once-only bits, even if no bit changes
  assign misc_wr = wr_fire && wr_lane_r && wr_pick[0];

  // a set request is masked by the current flag, so a cleared flag stays clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spec_flag_r <= ~pin_b_sync_r[1];
    end else if (misc_wr) begin
      spec_flag_r <= wr_byte_r[`MSMD_B_SPEC] & spec_flag_r;
    end
  end

  // mode a latch: free in special modes, a single write in normal modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_a_r <= pin_a_sync_r[1];
    end else if (misc_wr && (spec_flag_r || !mode_a_written_r)) begin
      mode_a_r <= wr_byte_r[`MSMD_B_MODEA];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_a_written_r <= 1'b0;
    end else if (misc_wr) begin
      mode_a_written_r <= 1'b1;
    end
  end

  // boot enable only moves while the special flag is still set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_r <= ~pin_b_sync_r[1] & ~pin_a_sync_r[1];
    end else if (misc_wr && spec_flag_r) begin
      boot_r <= wr_byte_r[`MSMD_B_BOOT];
    end
  end

  // visibility / E-off bit: one write in every mode, special or not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vis_eoff_r <= ~pin_b_sync_r[1] & pin_a_sync_r[1];
    end else if (misc_wr && !vis_written_r) begin
      vis_eoff_r <= wr_byte_r[`MSMD_B_VIS];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vis_written_r <= 1'b0;
    end else if (misc_wr) begin
      vis_written_r <= 1'b1;
    end
  end

  // priority select is plain storage; only the misc register readback reads it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psel_r <= `MSMD_PSEL_RST;
    end else if (misc_wr) begin
      psel_r <= wr_byte_r[`MSMD_F_PSEL];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      map_r <= `MSMD_MAP_RST;
    end else if (wr_fire && wr_lane_r && wr_pick[1]) begin
      map_r <= wr_byte_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `MSMD_CFG_RST;
    end else if (wr_fire && wr_lane_r && wr_pick[2]) begin
      cfg_r <= wr_byte_r;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wr_addr_r <= 16'h0000;
      wr_byte_r <= 8'h00;
      wr_lane_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSMD_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        wr_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wr_byte_r <= s_axi_wdata[7:0];
        wr_lane_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_pick == 8'h00 || wr_pick[3]) ? `MSMD_RESP_DEC : `MSMD_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;

  // ==========================================================
  // AXI4-Lite read channel
  logic [7:0] rd_pick;

  assign rd_pick = reg_pick(s_axi_araddr);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MSMD_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (rd_pick == 8'h00) ? `MSMD_RESP_DEC : `MSMD_RESP_OK;
      s_axi_rdata <= {24'h00_0000,
                      (rd_pick[0] ? misc_rd : 8'h00) |
                      (rd_pick[1] ? map_r : 8'h00) |
                      (rd_pick[2] ? cfg_r : 8'h00) |
                      (rd_pick[3] ? stat_rd : 8'h00)};
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // mode-derived enables
  logic expanded;
  logic rom_on;
  logic boot_on;
  logic ee_on;

  assign misc_rd = {boot_r, spec_flag_r, mode_a_r, vis_eoff_r, psel_r};
  // mode a latch set means expanded or special test; both use the external bus
  assign expanded = mode_a_r;
  assign rom_on = !expanded || cfg_r[`MSMD_B_ROM_EN];
  assign boot_on = boot_r && spec_flag_r;
  assign ee_on = cfg_r[`MSMD_B_EEON];
  assign stat_rd = {3'b000, ee_on, boot_on, rom_on, mode_r};

  // ==========================================================
  // address decode by fixed precedence
  logic [15:0] reg_base;
  logic [15:0] ram_base;
  logic [15:0] ee_lo;
  logic [15:0] ram_hi;
  logic hit_reg;
  logic hit_ram;
  logic hit_boot;
  logic hit_ee;
  logic hit_rom;
  msmd_sel_t sel_nxt;

  assign ram_base = {map_r[7:4], 12'h000} & `MSMD_PAGE_MASK;
  assign reg_base = {map_r[3:0], 12'h000} & `MSMD_PAGE_MASK;
  assign ram_hi = ram_base + 16'(RAM_BYTES - 1);
  assign ee_lo = EE_LARGE ? ({cfg_r[`MSMD_F_EEPG], 12'h000} | `MSMD_EEL_OFF) : `MSMD_EES_LO;
  assign hit_reg = (cpu_addr & `MSMD_REG_MASK) == reg_base;
  assign hit_ram = in_range(cpu_addr, ram_base, ram_hi);
  assign hit_boot = boot_on && in_range(cpu_addr, `MSMD_BOOT_LO, `MSMD_BOOT_HI);
  assign hit_ee = ee_on && (EE_LARGE ? ((cpu_addr & `MSMD_EEL_MASK) == ee_lo)
                                     : in_range(cpu_addr, `MSMD_EES_LO, `MSMD_EES_HI));
  assign hit_rom = rom_on && in_range(cpu_addr, ROM_BASE, `MSMD_TOP);

  // one winner only, so a shadowed resource never sees the strobe
  always_comb begin
    if (hit_reg) begin
      sel_nxt = MSMD_SEL_REGS;
    end else if (hit_ram) begin
      sel_nxt = MSMD_SEL_RAM;
    end else if (hit_boot) begin
      sel_nxt = MSMD_SEL_BOOT;
    end else if (hit_ee) begin
      sel_nxt = MSMD_SEL_EEPROM;
    end else if (hit_rom) begin
      sel_nxt = MSMD_SEL_ROM;
    end else if (expanded) begin
      sel_nxt = MSMD_SEL_EXT;
    end else begin
      sel_nxt = MSMD_SEL_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_sel <= MSMD_SEL_NONE;
    end else begin
      cpu_sel <= cpu_valid ? sel_nxt : MSMD_SEL_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_cycle <= 1'b0;
    end else begin
      ext_cycle <= cpu_valid && (sel_nxt == MSMD_SEL_EXT);
    end
  end

  // only internal reads are echoed; external cycles own the data bus already
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_data_drive <= 1'b0;
    end else begin
      ext_data_drive <= cpu_valid && !cpu_write && expanded && vis_eoff_r &&
                        (sel_nxt != MSMD_SEL_EXT) && (sel_nxt != MSMD_SEL_NONE);
    end
  end

  // ==========================================================
  // reset vector, E clock and fetch marker
  logic [7:0] ediv_r;
  logic eclk_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_vector <= `MSMD_VEC_NORM;
    end else begin
      reset_vector <= spec_flag_r ? `MSMD_VEC_SPEC : `MSMD_VEC_NORM;
    end
  end

  // E is the clock divided by E_DIV, or by E_DIV-1 when E_DIV is odd; the enable pulse keeps one clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ediv_r <= 8'h00;
      eclk_r <= 1'b0;
    end else if (ediv_r == 8'(E_DIV / 2 - 1)) begin
      ediv_r <= 8'h00;
      eclk_r <= ~eclk_r;
    end else begin
      ediv_r <= ediv_r + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eclk_pin <= 1'b0;
    end else begin
      eclk_pin <= eclk_r && (expanded || !vis_eoff_r);
    end
  end

  // open drain: never drives high, released during reset so straps read cleanly
  assign mode_pin_a_out = 1'b0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_pin_a_oe <= 1'b0;
    end else begin
      mode_pin_a_oe <= cpu_fetch_first;
    end
  end
endmodule
`default_nettype wire
